// *** dcca_pkg.sv ***
package dcca_pkg;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int OFS_W = 8;

  // Register byte offsets on the register bus.
  localparam logic [7:0] OFS_CTL = 8'h00;
  localparam logic [7:0] OFS_SA = 8'h04;
  localparam logic [7:0] OFS_DA = 8'h08;
  localparam logic [7:0] OFS_SZ = 8'h0C;
  localparam logic [7:0] OFS_NMI = 8'h10;

  // Field positions in channel_control.
  localparam int CTL_MODE_HI = 14;
  localparam int CTL_MODE_LO = 12;
  localparam int CTL_DSTEP_HI = 11;
  localparam int CTL_DSTEP_LO = 10;
  localparam int CTL_SSTEP_HI = 9;
  localparam int CTL_SSTEP_LO = 8;
  localparam int CTL_DST_BYTE = 7;
  localparam int CTL_SRC_BYTE = 6;
  localparam int CTL_LEVEL = 5;
  localparam int CTL_EN = 4;
  localparam int CTL_IFG = 3;
  localparam int CTL_IE = 2;
  localparam int CTL_ABORT = 1;
  localparam int CTL_REQ = 0;
  localparam int NMI_EN_BIT = 0;

  // Reset values.
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [19:0] ADDR_RST = 20'h00000;
  localparam logic [15:0] SZ_RST = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  // Address step codes; the two low codes leave the address fixed.
  localparam logic [1:0] STEP_DEC = 2'h2;
  localparam logic [1:0] STEP_INC = 2'h3;
  localparam logic [19:0] STEP_BYTE = 20'h00001;
  localparam logic [19:0] STEP_WORD = 20'h00002;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    DCCA_SINGLE = 3'h0,
    DCCA_BLOCK = 3'h1,
    DCCA_BURST_A = 3'h2,
    DCCA_BURST_B = 3'h3,
    DCCA_REP_SINGLE = 3'h4,
    DCCA_REP_BLOCK = 3'h5,
    DCCA_REP_BURST_A = 3'h6,
    DCCA_REP_BURST_B = 3'h7
  } dcca_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_GAP = 4'b1000
  } dcca_state_t;

endpackage

// *** dcca_addr_step.sv ***
module dcca_addr_step
  import dcca_pkg::*;
(
  input wire logic [dcca_pkg::ADDR_W-1:0] addr,
  input wire logic [1:0] step,
  input wire logic byte_mode,
  output logic [dcca_pkg::ADDR_W-1:0] next_addr
);

  logic [ADDR_W-1:0] delta;

  always_comb begin
    delta = byte_mode ? STEP_BYTE : STEP_WORD;
    case (step)
      STEP_DEC: next_addr = addr - delta;
      STEP_INC: next_addr = addr + delta;
      default: next_addr = addr;
    endcase
  end

endmodule

// *** dcca_channel.sv ***
// Functional notes
// - Mode 111b: repeated burst-block transfers.
// - Mode codes select single, block, burst, repeated.
// - Destination step: fixed, decrement, increment.
// - Destination steps one for byte, two word.
// - Destination steps a working copy only.
// - Source step: fixed, decrement, increment.
// - Source steps one for byte, two word.
// - Source steps a working copy only.
// - Control bit 7: destination byte or word.
// - Control bit 6: source byte or word.
// - Control bit 5: edge or level trigger.
// - Bit 3 pending flag, bit 2 enables it.
// - Bit 1 set when NMI aborts transfer.
// - NMI: finish unit, stop, set abort.
// - Bit 0 starts by software, self-clears.
// - Count decrements, reloads; zero count disables.
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
module dcca_channel
  import dcca_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic dma_trigger,
  input wire logic nmi_event,
  output logic mem_req,
  output logic mem_write,
  output logic mem_byte,
  output logic [dcca_pkg::ADDR_W-1:0] mem_addr,
  output logic [dcca_pkg::DATA_W-1:0] mem_wdata,
  input wire logic [dcca_pkg::DATA_W-1:0] mem_rdata,
  input wire logic mem_ack,
  output logic channel_irq
);
  import dcca_pkg::*;

  function automatic logic mode_repeat(input dcca_mode_t m);
    case (m)
      DCCA_REP_SINGLE, DCCA_REP_BLOCK, DCCA_REP_BURST_A, DCCA_REP_BURST_B: mode_repeat = 1'b1;
      default: mode_repeat = 1'b0;
    endcase
  endfunction

  function automatic logic mode_single(input dcca_mode_t m);
    case (m)
      DCCA_SINGLE, DCCA_REP_SINGLE: mode_single = 1'b1;
      default: mode_single = 1'b0;
    endcase
  endfunction

  function automatic logic mode_burst(input dcca_mode_t m);
    case (m)
      DCCA_BURST_A, DCCA_BURST_B, DCCA_REP_BURST_A, DCCA_REP_BURST_B: mode_burst = 1'b1;
      default: mode_burst = 1'b0;
    endcase
  endfunction

  // Configuration fields of channel_control, plus nmi_en from the NMI register.
  dcca_mode_t mode;
  logic [1:0] dst_step;
  logic [1:0] src_step;
  logic dst_byte;
  logic src_byte;
  logic level;
  logic irq_en;
  logic nmi_en;
  // Fields that the engine also changes, then the software-only addresses and size, and engine state.
  logic chan_en;
  logic ifg;
  logic abort;
  logic sw_req;
  logic [ADDR_W-1:0] src_addr;
  logic [ADDR_W-1:0] dst_addr;
  logic [15:0] size;
  logic [15:0] count;
  logic [ADDR_W-1:0] src_work;
  logic [ADDR_W-1:0] dst_work;
  logic [ADDR_W-1:0] next_src;
  logic [ADDR_W-1:0] next_dst;
  dcca_state_t state;
  logic stop_pend;
  logic trig_pend;

  // Bus data phase bookkeeping.
  logic ph_wr;
  logic [OFS_W-1:0] ph_addr;
  logic [31:0] rd_word;

  // Pin synchronisers; only the second and third stages feed logic.
  logic trig_meta;
  logic trig_sync;
  logic trig_prev;
  logic nmi_meta;
  logic nmi_sync;
  logic nmi_prev;

  logic wr_ctl;
  logic wr_sz;
  logic en_rise;
  logic trig_rise;
  logic nmi_rise;
  logic start_ok;
  logic last_unit;
  logic stop_now;
  logic [15:0] ctl_word;

  dcca_addr_step u_src_step (
    .addr(src_work),
    .step(src_step),
    .byte_mode(src_byte),
    .next_addr(next_src)
  );

  dcca_addr_step u_dst_step (
    .addr(dst_work),
    .step(dst_step),
    .byte_mode(dst_byte),
    .next_addr(next_dst)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
      nmi_meta <= 1'b0;
      nmi_sync <= 1'b0;
      nmi_prev <= 1'b0;
    end else if (ce) begin
      trig_meta <= dma_trigger;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
      nmi_meta <= nmi_event;
      nmi_sync <= nmi_meta;
      nmi_prev <= nmi_sync;
    end
  end

  assign trig_rise = trig_sync && !trig_prev;
  assign nmi_rise = nmi_sync && !nmi_prev;

  assign wr_ctl = ph_wr && (ph_addr == OFS_CTL);
  assign wr_sz = ph_wr && (ph_addr == OFS_SZ);
  assign en_rise = wr_ctl && hwdata[CTL_EN] && !chan_en;
  assign last_unit = (count == CNT_ONE);
  assign stop_now = stop_pend || (nmi_rise && nmi_en);

  // A zero count or a cleared enable keeps every request out.
  assign start_ok = chan_en && (count != CNT_ZERO) && (size != CNT_ZERO)
                    && (sw_req || (level ? trig_sync : trig_pend));

  assign ctl_word = {1'b0, mode, dst_step, src_step, dst_byte, src_byte, level,
                     chan_en, ifg, irq_en, abort, sw_req};

  always_comb begin
    case (haddr[OFS_W-1:0])
      OFS_CTL: rd_word = {16'h0000, ctl_word};
      OFS_SA: rd_word = {12'h000, src_addr};
      OFS_DA: rd_word = {12'h000, dst_addr};
      OFS_SZ: rd_word = {16'h0000, count};
      OFS_NMI: rd_word = {31'h00000000, nmi_en};
      default: rd_word = 32'h00000000;
    endcase
  end

  // Zero-wait slave: the read word is sampled at the end of the address phase.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ph_wr <= 1'b0;
      ph_addr <= '0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
      if (hready) begin
        ph_wr <= hsel && htrans[1] && hwrite;
        ph_addr <= haddr[OFS_W-1:0];
        if (hsel && htrans[1] && !hwrite) begin
          hrdata <= rd_word;
        end else begin
          hrdata <= 32'h00000000;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode <= dcca_mode_t'(CTL_RST[CTL_MODE_HI:CTL_MODE_LO]);
      dst_step <= CTL_RST[CTL_DSTEP_HI:CTL_DSTEP_LO];
      src_step <= CTL_RST[CTL_SSTEP_HI:CTL_SSTEP_LO];
      dst_byte <= CTL_RST[CTL_DST_BYTE];
      src_byte <= CTL_RST[CTL_SRC_BYTE];
      level <= CTL_RST[CTL_LEVEL];
      irq_en <= CTL_RST[CTL_IE];
      nmi_en <= 1'b0;
      src_addr <= ADDR_RST;
      dst_addr <= ADDR_RST;
    end else if (ce) begin
      if (wr_ctl) begin
        mode <= dcca_mode_t'(hwdata[CTL_MODE_HI:CTL_MODE_LO]);
        dst_step <= hwdata[CTL_DSTEP_HI:CTL_DSTEP_LO];
        src_step <= hwdata[CTL_SSTEP_HI:CTL_SSTEP_LO];
        dst_byte <= hwdata[CTL_DST_BYTE];
        src_byte <= hwdata[CTL_SRC_BYTE];
        level <= hwdata[CTL_LEVEL];
        irq_en <= hwdata[CTL_IE];
      end
      if (ph_wr && (ph_addr == OFS_NMI)) begin
        nmi_en <= hwdata[NMI_EN_BIT];
      end
      if (ph_wr && (ph_addr == OFS_SA)) begin
        src_addr <= hwdata[ADDR_W-1:0];
      end
      if (ph_wr && (ph_addr == OFS_DA)) begin
        dst_addr <= hwdata[ADDR_W-1:0];
      end
    end
  end

  // Interrupt output is ifg gated by its enable, one cycle behind the bits.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      channel_irq <= 1'b0;
    end else if (ce) begin
      channel_irq <= ifg && irq_en;
    end
  end

  // Transfer engine. Hardware updates sit after software writes so the hardware update wins, set or clear.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      chan_en <= CTL_RST[CTL_EN];
      ifg <= CTL_RST[CTL_IFG];
      abort <= CTL_RST[CTL_ABORT];
      sw_req <= CTL_RST[CTL_REQ];
      size <= SZ_RST;
      count <= SZ_RST;
      src_work <= ADDR_RST;
      dst_work <= ADDR_RST;
      stop_pend <= 1'b0;
      trig_pend <= 1'b0;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_byte <= 1'b0;
      mem_addr <= ADDR_RST;
      mem_wdata <= '0;
    end else if (ce) begin
      if (wr_ctl) begin
        chan_en <= hwdata[CTL_EN];
        ifg <= hwdata[CTL_IFG];
        abort <= hwdata[CTL_ABORT];
        if (hwdata[CTL_REQ] && hwdata[CTL_EN]) begin
          sw_req <= 1'b1;
        end
        // A start left pending by a disabling write is dropped, unless a trigger edge lands in that same cycle and sets trig_pend again.
        if (!hwdata[CTL_EN]) begin
          trig_pend <= 1'b0;
          sw_req <= 1'b0;
        end
      end
      if (en_rise) begin
        src_work <= src_addr;
        dst_work <= dst_addr;
        stop_pend <= 1'b0;
      end
      if (wr_sz) begin
        size <= hwdata[15:0];
        count <= hwdata[15:0];
      end
      if (chan_en && !level && trig_rise) begin
        trig_pend <= 1'b1;
      end
      if (nmi_rise && nmi_en && (state != ST_IDLE)) begin
        stop_pend <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (start_ok) begin
            sw_req <= 1'b0;
            trig_pend <= 1'b0;
            mem_req <= 1'b1;
            mem_write <= 1'b0;
            mem_addr <= src_work;
            mem_byte <= src_byte;
            state <= ST_READ;
          end
        end
        ST_READ: begin
          if (mem_ack) begin
            mem_write <= 1'b1;
            mem_addr <= dst_work;
            mem_byte <= dst_byte;
            mem_wdata <= src_byte ? {8'h00, mem_rdata[7:0]} : mem_rdata;
            state <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            src_work <= next_src;
            dst_work <= next_dst;
            if (last_unit) begin
              count <= size;
              ifg <= 1'b1;
              if (mode_repeat(mode)) begin
                src_work <= src_addr;
                dst_work <= dst_addr;
              end else begin
                chan_en <= 1'b0;
              end
            end else begin
              count <= count - CNT_ONE;
            end
            if (stop_now) begin
              chan_en <= 1'b0;
              abort <= 1'b1;
              stop_pend <= 1'b0;
              state <= ST_IDLE;
            end else if (!last_unit && !mode_single(mode)) begin
              if (mode_burst(mode)) begin
                state <= ST_GAP;
              end else begin
                mem_req <= 1'b1;
                mem_addr <= next_src;
                mem_byte <= src_byte;
                state <= ST_READ;
              end
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        // Burst-block leaves one free bus cycle between units for the CPU.
        ST_GAP: begin
          mem_req <= 1'b1;
          mem_write <= 1'b0;
          mem_addr <= src_work;
          mem_byte <= src_byte;
          state <= ST_READ;
        end
        default: begin
          state <= ST_IDLE;
          mem_req <= 1'b0;
          mem_write <= 1'b0;
        end
      endcase
    end
  end

endmodule

// *** dcca_channel_asserts.sv ***
module dcca_channel_asserts
  import dcca_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic mem_byte,
  input wire logic [dcca_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [dcca_pkg::DATA_W-1:0] mem_wdata,
  input wire logic [dcca_pkg::DATA_W-1:0] mem_rdata,
  input wire logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_acc;
  assign rd_acc = ce && hsel && hready && htrans[1] && !hwrite;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_req_hold;
    mem_req && !mem_ack |=> mem_req && $stable({mem_write, mem_byte, mem_addr, mem_wdata});
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("memory request changed before acknowledge");
  property p_read_then_write;
    mem_req && mem_ack && !mem_write |=> mem_req && mem_write;
  endproperty
  a_read_then_write: assert property (p_read_then_write)
    else $error("write did not follow read");
  property p_byte_write;
    mem_req && mem_write && mem_byte |-> mem_wdata[15:8] == 8'h00;
  endproperty
  a_byte_write: assert property (p_byte_write)
    else $error("byte write carries high byte");
  property p_copy_low;
    mem_ack && !mem_write |=> mem_wdata[7:0] == $past(mem_rdata[7:0]);
  endproperty
  a_copy_low: assert property (p_copy_low)
    else $error("write data differs from read data");
  property p_upper_zero;
    hrdata[31:20] == 12'h000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("reserved read bits not zero");
  property p_ctl_top;
    rd_acc && haddr[7:0] == OFS_CTL |=> hrdata[31:15] == 17'h00000;
  endproperty
  a_ctl_top: assert property (p_ctl_top)
    else $error("control read has bits above mode field");
  property p_idle_rdata;
    !rd_acc |=> hrdata == 32'h00000000;
  endproperty
  a_idle_rdata: assert property (p_idle_rdata)
    else $error("read data outside data phase");
  property p_bus_ok;
    hreadyout && hresp == HRESP_OKAY;
  endproperty
  a_bus_ok: assert property (p_bus_ok)
    else $error("bus not ready or not okay");
endmodule

bind dcca_channel dcca_channel_asserts dcca_channel_asserts_i (
  .clk, .sys_rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
  .hresp, .mem_req, .mem_write, .mem_byte, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack
);

// *** dcca_mem_model.sv ***
module dcca_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic mem_byte,
  input wire logic [19:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [1:0] delay,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  output logic [19:0] last_addr,
  output logic [15:0] last_data,
  output logic last_byte,
  output logic [7:0] wr_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] waited;
  logic [15:0] pattern;
  // Outside an acknowledge the bus shows the inverse, so a stale sample never matches.
  assign pattern = mem_addr[15:0] ^ 16'h5A5A;
  assign mem_rdata = mem_ack ? pattern : ~pattern;
  always_ff @(posedge clk) begin
    if (rst || mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      waited <= 2'h0;
    end else if (waited == delay) begin
      mem_ack <= 1'b1;
    end else begin
      waited <= waited + 2'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_count <= 8'h00;
    end else if (mem_ack && mem_write) begin
      wr_count <= wr_count + 8'h01;
      last_addr <= mem_addr;
      last_data <= mem_wdata;
      last_byte <= mem_byte;
    end
  end
endmodule

// *** tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dcca_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic dma_trigger = 1'b0;
  logic nmi_event = 1'b0;
  logic [1:0] delay = 2'h0;
  logic [31:0] hrdata, rd;
  logic hready, hresp, mem_req, mem_write, mem_byte, mem_ack, channel_irq, last_byte;
  logic [19:0] mem_addr, last_addr;
  logic [15:0] mem_wdata, mem_rdata, last_data;
  logic [7:0] wr_count;
  logic [7:0] nw = 8'h00;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  initial forever #2 clk = ~clk;
  dcca_channel dcca_channel_i (
    .clk, .sys_rst, .ce(1'b1), .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp, .dma_trigger, .nmi_event, .mem_req,
    .mem_write, .mem_byte, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .channel_irq
  );
  dcca_mem_model dcca_mem_model_i (
    .clk, .rst(sys_rst), .mem_req, .mem_write, .mem_byte, .mem_addr, .mem_wdata, .delay,
    .mem_rdata, .mem_ack, .last_addr, .last_data, .last_byte, .wr_count
  );
  task automatic results();
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_wr(input int k);
    nw += k;
    repeat (400) if (wr_count !== nw) @(posedge clk);
    check(wr_count, nw);
  endtask
  function automatic logic [31:0] ctl(input logic [2:0] m, input logic [3:0] st,
      input logic [2:0] bl, input logic en);
    return {17'h0, m, st, bl, en, 3'h0, en};
  endfunction
  task automatic t_regs();
    bus(OFS_CTL, 1'b0, 32'h0);
    check(rd, 32'h0);
    bus(OFS_SA, 1'b1, 32'hFFFFFFFF);
    bus(OFS_SA, 1'b0, 32'h0);
    check(rd, 32'h000FFFFF);
    bus(8'h20, 1'b0, 32'h0);
    check(rd, 32'h0);
  endtask
  task automatic t_single();
    bus(OFS_SA, 1'b1, 32'h100);
    bus(OFS_DA, 1'b1, 32'h200);
    bus(OFS_SZ, 1'b1, 32'h2);
    bus(OFS_CTL, 1'b1, ctl(3'h0, 4'hF, 3'h0, 1'b1));
    wait_wr(1);
    check(last_addr, 32'h200);
    check(last_data, 16'h0100 ^ 16'h5A5A);
    check(last_byte, 1'b0);
    bus(OFS_CTL, 1'b0, 32'h0);
    check(rd, 32'h00000F10);
    bus(OFS_CTL, 1'b1, ctl(3'h0, 4'hF, 3'h0, 1'b1));
    wait_wr(1);
    check(last_addr, 32'h202);
    check(last_data, 16'h0102 ^ 16'h5A5A);
    bus(OFS_CTL, 1'b0, 32'h0);
    check(rd, 32'h00000F08);
    bus(OFS_SA, 1'b0, 32'h0);
    check(rd, 32'h100);
    bus(OFS_SZ, 1'b0, 32'h0);
    check(rd, 32'h2);
  endtask
  task automatic t_block();
    delay <= 2'h2;
    bus(OFS_SA, 1'b1, 32'h300);
    bus(OFS_DA, 1'b1, 32'h400);
    bus(OFS_SZ, 1'b1, 32'h3);
    bus(OFS_CTL, 1'b1, ctl(3'h1, 4'hA, 3'h6, 1'b1));
    wait_wr(3);
    check(last_addr, 32'h3FE);
    check(last_data, (16'h02FE ^ 16'h5A5A) & 16'h00FF);
    check(last_byte, 1'b1);
    bus(OFS_DA, 1'b0, 32'h0);
    check(rd, 32'h400);
    delay <= 2'h0;
  endtask
  task automatic t_refuse();
    bus(OFS_CTL, 1'b1, 32'h1);
    repeat (30) @(posedge clk);
    check(wr_count, nw);
    bus(OFS_SZ, 1'b1, 32'h0);
    bus(OFS_CTL, 1'b1, ctl(3'h1, 4'hF, 3'h0, 1'b1));
    repeat (30) @(posedge clk);
    check(wr_count, nw);
    bus(OFS_CTL, 1'b1, 32'h0);
  endtask
  task automatic t_trig();
    bus(OFS_SZ, 1'b1, 32'h2);
    bus(OFS_CTL, 1'b1, ctl(3'h0, 4'hF, 3'h0, 1'b1) & 32'hFFFFFFFE);
    dma_trigger <= 1'b1;
    wait_wr(1);
    repeat (30) @(posedge clk);
    check(wr_count, nw);
    dma_trigger <= 1'b0;
    bus(OFS_CTL, 1'b1, ctl(3'h4, 4'hF, 3'h1, 1'b1) & 32'hFFFFFFFE);
    dma_trigger <= 1'b1;
    wait_wr(3);
    dma_trigger <= 1'b0;
    bus(OFS_CTL, 1'b1, 32'h0);
    repeat (20) @(posedge clk);
    nw = wr_count;
  endtask
  task automatic t_modes();
    logic s;
    for (int m = 0; m < 8; m++) begin
      s = (m[1:0] == 2'h0);
      bus(OFS_CTL, 1'b1, 32'h0);
      bus(OFS_SZ, 1'b1, 32'h2);
      bus(OFS_CTL, 1'b1, ctl(m[2:0], 4'hF, 3'h0, 1'b1) | 32'h4);
      wait_wr(s ? 1 : 2);
      bus(OFS_CTL, 1'b0, 32'h0);
      check(rd[4:3], {m[2] | s, !s});
      check(channel_irq, !s);
    end
    bus(OFS_CTL, 1'b1, 32'h0);
  endtask
  task automatic t_nmi();
    logic [7:0] n1;
    delay <= 2'h1;
    bus(OFS_NMI, 1'b1, 32'h1);
    bus(OFS_SZ, 1'b1, 32'h28);
    bus(OFS_CTL, 1'b1, ctl(3'h1, 4'hF, 3'h0, 1'b1));
    wait_wr(1);
    nmi_event <= 1'b1;
    repeat (4) @(posedge clk);
    nmi_event <= 1'b0;
    repeat (20) @(posedge clk);
    n1 = wr_count;
    bus(OFS_CTL, 1'b0, 32'h0);
    check(rd[4:1], 4'h1);
    repeat (40) @(posedge clk);
    check(wr_count, n1);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_single();
    t_block();
    t_refuse();
    t_trig();
    t_modes();
    t_nmi();
    results();
  end
endmodule
